// [operand_addr_gen.sv]
`timescale 1ns/10ps
module operand_addr_gen (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  // Sequencer request
  input  wire logic                       start,
  input  wire operand_addr_pkg::kind_type kind,
  input  wire operand_addr_pkg::mode_type src_mode,
  input  wire operand_addr_pkg::mode_type dst_mode,
  input  wire logic                       wide_operand,
  input  wire logic [15:0]                opcode_addr,
  input  wire logic [2:0]                 bit_select,
  input  wire logic [7:0]                 reg_operand,
  input  wire logic [7:0]                 store_operand,
  input  wire logic [15:0]                stack_ptr,
  input  wire logic                       branch_cond,
  // Memory space
  output logic [15:0]                     mem_addr,
  output logic                            mem_read,
  output logic                            mem_write,
  output logic [7:0]                      mem_wdata,
  input  wire logic [7:0]                 mem_rdata,
  // Sequencer result
  output logic                            busy,
  output logic                            done,
  output logic [15:0]                     operand,
  output logic [15:0]                     operand_addr,
  output logic [15:0]                     next_pc,
  output logic                            branch_taken,
  output logic [15:0]                     stack_out,
  output logic                            pop_valid,
  output logic [7:0]                      pop_data,
  output logic                            fill_valid,
  output logic [7:0]                      fill_data
);

  operand_addr_pkg::state_type state_q;
  operand_addr_pkg::kind_type  kind_q;
  operand_addr_pkg::mode_type  src_mode_q;
  operand_addr_pkg::mode_type  dst_mode_q;
  logic                        wide_q;
  logic [2:0]                  bit_q;
  logic [7:0]                  reg_q;
  logic [7:0]                  store_q;
  logic                        cond_q;
  logic                        step_q;
  logic [2:0]                  count_q;
  logic [15:0]                 ptr_q;
  logic [15:0]                 sp_q;
  logic [15:0]                 ea_q;
  logic [15:0]                 operand_q;
  logic [15:0]                 next_pc_q;
  logic                        taken_q;
  logic [15:0]                 mem_addr_q;
  logic                        mem_read_q;
  logic                        mem_write_q;
  logic [7:0]                  mem_wdata_q;
  logic                        busy_q;
  logic                        done_q;
  logic                        pop_valid_q;
  logic [7:0]                  pop_data_q;
  logic                        fill_valid_q;
  logic [7:0]                  fill_data_q;

  logic [15:0]                 ptr_next;
  logic [15:0]                 target;
  logic                        cond_true;
  logic [7:0]                  decremented;
  operand_addr_pkg::state_type after_src;

  localparam logic [2:0] RTI_LAST    = operand_addr_pkg::RTI_FRAME_BYTES - 3'h1;
  localparam logic [2:0] RTI_PC_HIGH = operand_addr_pkg::RTI_FRAME_BYTES - 3'h2;
  localparam logic [2:0] FILL_LAST   = operand_addr_pkg::PIPE_FILL_BYTES - 3'h1;

  // A read is answered in the same cycle, so each byte costs two cycles
  assign ptr_next = ptr_q + operand_addr_pkg::PC_STEP;

  always_comb begin
    unique case (kind_q)
      operand_addr_pkg::kind_load: after_src = operand_addr_pkg::st_done;
      operand_addr_pkg::kind_move: after_src = operand_addr_pkg::st_dst;
      default:                     after_src = operand_addr_pkg::st_branch;
    endcase
  end

  branch_test u_test (
    .kind        (kind_q),
    .operand     (operand_q[7:0]),
    .bit_select  (bit_q),
    .compare     (reg_q),
    .cond_in     (cond_q),
    .taken       (cond_true),
    .decremented (decremented)
  );

  // Base is the address after the displacement byte
  branch_target u_target (
    .base_pc      (ptr_next),
    .displacement (mem_rdata),
    .target       (target)
  );

  // Request capture and sequencing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q      <= operand_addr_pkg::st_idle;
      kind_q       <= operand_addr_pkg::kind_load;
      src_mode_q   <= operand_addr_pkg::register_only_mode;
      dst_mode_q   <= operand_addr_pkg::register_only_mode;
      wide_q       <= 1'b0;
      bit_q        <= 3'h0;
      reg_q        <= operand_addr_pkg::BYTE_RESET;
      store_q      <= operand_addr_pkg::BYTE_RESET;
      cond_q       <= 1'b0;
      step_q       <= 1'b0;
      count_q      <= 3'h0;
      ptr_q        <= operand_addr_pkg::ADDR_RESET;
      sp_q         <= operand_addr_pkg::ADDR_RESET;
      ea_q         <= operand_addr_pkg::ADDR_RESET;
      operand_q    <= operand_addr_pkg::ADDR_RESET;
      next_pc_q    <= operand_addr_pkg::ADDR_RESET;
      taken_q      <= 1'b0;
      mem_addr_q   <= operand_addr_pkg::ADDR_RESET;
      mem_read_q   <= 1'b0;
      mem_write_q  <= 1'b0;
      mem_wdata_q  <= operand_addr_pkg::BYTE_RESET;
      busy_q       <= 1'b0;
      done_q       <= 1'b0;
      pop_valid_q  <= 1'b0;
      pop_data_q   <= operand_addr_pkg::BYTE_RESET;
      fill_valid_q <= 1'b0;
      fill_data_q  <= operand_addr_pkg::BYTE_RESET;
    end else begin
      mem_read_q   <= 1'b0;
      mem_write_q  <= 1'b0;
      done_q       <= 1'b0;
      pop_valid_q  <= 1'b0;
      fill_valid_q <= 1'b0;
      unique case (state_q)
        operand_addr_pkg::st_idle: begin
          if (start) begin
            kind_q     <= kind;
            src_mode_q <= src_mode;
            dst_mode_q <= dst_mode;
            wide_q     <= wide_operand;
            bit_q      <= bit_select;
            reg_q      <= reg_operand;
            store_q    <= store_operand;
            cond_q     <= branch_cond;
            sp_q       <= stack_ptr;
            ptr_q      <= opcode_addr + operand_addr_pkg::PC_STEP;
            step_q     <= 1'b0;
            count_q    <= 3'h0;
            taken_q    <= 1'b0;
            busy_q     <= 1'b1;
            if (kind == operand_addr_pkg::return_from_interrupt) begin
              state_q <= operand_addr_pkg::st_pop;
            end else if (kind == operand_addr_pkg::kind_branch) begin
              state_q <= operand_addr_pkg::st_branch;
            end else if (kind == operand_addr_pkg::kind_store) begin
              state_q <= operand_addr_pkg::st_dst;
            end else begin
              state_q <= operand_addr_pkg::st_src;
            end
          end
        end
        operand_addr_pkg::st_src: begin
          unique case (src_mode_q)
            operand_addr_pkg::inline_operand_mode: begin
              if (!mem_read_q) begin
                mem_read_q <= 1'b1;
                mem_addr_q <= ptr_q;
              end else begin
                ptr_q <= ptr_next;
                if (wide_q && !step_q) begin
                  operand_q[15:8] <= mem_rdata;
                  step_q          <= 1'b1;
                end else begin
                  if (wide_q) begin
                    operand_q[7:0] <= mem_rdata;
                  end else begin
                    operand_q <= {8'h00, mem_rdata};
                  end
                  step_q  <= 1'b0;
                  state_q <= after_src;
                end
              end
            end
            operand_addr_pkg::zero_page_mode: begin
              if (!mem_read_q) begin
                mem_read_q <= 1'b1;
                mem_addr_q <= step_q ? ea_q : ptr_q;
              end else if (!step_q) begin
                ea_q   <= {operand_addr_pkg::ZERO_PAGE_HIGH, mem_rdata};
                ptr_q  <= ptr_next;
                step_q <= 1'b1;
              end else begin
                operand_q <= {8'h00, mem_rdata};
                step_q    <= 1'b0;
                state_q   <= after_src;
              end
            end
            operand_addr_pkg::register_only_mode, operand_addr_pkg::pc_offset_mode: begin
              // No memory cycle at all for register-only or PC-offset sources; both take reg_q
              operand_q <= {8'h00, reg_q};
              state_q   <= after_src;
            end
          endcase
        end
        operand_addr_pkg::st_dst: begin
          if (dst_mode_q == operand_addr_pkg::zero_page_mode) begin
            if (!mem_read_q) begin
              mem_read_q <= 1'b1;
              mem_addr_q <= ptr_q;
            end else begin
              ea_q    <= {operand_addr_pkg::ZERO_PAGE_HIGH, mem_rdata};
              ptr_q   <= ptr_next;
              state_q <= operand_addr_pkg::st_write;
            end
          end else begin
            // Register target: value handed back on operand
            if (kind_q == operand_addr_pkg::kind_store) begin
              operand_q <= {8'h00, store_q};
            end
            next_pc_q <= ptr_q;
            state_q   <= operand_addr_pkg::st_done;
          end
        end
        operand_addr_pkg::st_write: begin
          mem_write_q <= 1'b1;
          mem_addr_q  <= ea_q;
          mem_wdata_q <= (kind_q == operand_addr_pkg::kind_store) ? store_q : operand_q[7:0];
          // Counter write-back keeps the branch result already chosen
          if (kind_q != operand_addr_pkg::decrement_branch_if_not_zero) next_pc_q <= ptr_q;
          state_q     <= operand_addr_pkg::st_done;
        end
        operand_addr_pkg::st_branch: begin
          if (!mem_read_q) begin
            mem_read_q <= 1'b1;
            mem_addr_q <= ptr_q;
          end else begin
            ptr_q   <= ptr_next;
            taken_q <= cond_true;
            next_pc_q <= cond_true ? target : ptr_next;
            if (kind_q == operand_addr_pkg::decrement_branch_if_not_zero) begin
              operand_q <= {8'h00, decremented};
            end
            // Memory counter written back after the decrement
            if (kind_q == operand_addr_pkg::decrement_branch_if_not_zero &&
                src_mode_q == operand_addr_pkg::zero_page_mode) begin
              state_q <= operand_addr_pkg::st_write;
            end else begin
              state_q <= operand_addr_pkg::st_done;
            end
          end
        end
        operand_addr_pkg::st_pop: begin
          if (!mem_read_q) begin
            mem_read_q <= 1'b1;
            mem_addr_q <= sp_q + operand_addr_pkg::PC_STEP;
          end else begin
            sp_q        <= sp_q + operand_addr_pkg::PC_STEP;
            pop_valid_q <= 1'b1;
            pop_data_q  <= mem_rdata;
            count_q     <= count_q + 3'h1;
            // Counter pair comes off last, high byte first
            if (count_q == RTI_PC_HIGH) begin
              ptr_q[15:8] <= mem_rdata;
            end
            if (count_q == RTI_LAST) begin
              ptr_q[7:0] <= mem_rdata;
              next_pc_q  <= {ptr_q[15:8], mem_rdata};
              count_q    <= 3'h0;
              state_q    <= operand_addr_pkg::st_fill;
            end
          end
        end
        operand_addr_pkg::st_fill: begin
          if (!mem_read_q) begin
            mem_read_q <= 1'b1;
            mem_addr_q <= ptr_q;
          end else begin
            ptr_q        <= ptr_next;
            fill_valid_q <= 1'b1;
            fill_data_q  <= mem_rdata;
            count_q      <= count_q + 3'h1;
            if (count_q == FILL_LAST) begin
              count_q <= 3'h0;
              state_q <= operand_addr_pkg::st_done;
            end
          end
        end
        operand_addr_pkg::st_done: begin
          done_q  <= 1'b1;
          busy_q  <= 1'b0;
          if (kind_q == operand_addr_pkg::kind_load) next_pc_q <= ptr_q;
          state_q <= operand_addr_pkg::st_idle;
        end
      endcase
    end
  end

  assign mem_addr     = mem_addr_q;
  assign mem_read     = mem_read_q;
  assign mem_write    = mem_write_q;
  assign mem_wdata    = mem_wdata_q;
  assign busy         = busy_q;
  assign done         = done_q;
  assign operand      = operand_q;
  assign operand_addr = ea_q;
  assign next_pc      = next_pc_q;
  assign branch_taken = taken_q;
  assign stack_out    = sp_q;
  assign pop_valid    = pop_valid_q;
  assign pop_data     = pop_data_q;
  assign fill_valid   = fill_valid_q;
  assign fill_data    = fill_data_q;

endmodule // operand_addr_gen

// [operand_addr_pkg.sv]
package operand_addr_pkg;

  // One linear space for RAM, registers, I/O and program memory
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  localparam logic [7:0]  ZERO_PAGE_HIGH = 8'h00;
  localparam logic [15:0] PC_STEP        = 16'h0001;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [7:0]  DEC_STEP       = 8'h01;

  // Bytes pulled back on return and bytes refilled into the pipeline
  localparam logic [2:0]  RTI_FRAME_BYTES = 3'h5;
  localparam logic [2:0]  PIPE_FILL_BYTES = 3'h3;

  typedef enum logic [1:0] {
    register_only_mode  = 2'h0,
    inline_operand_mode = 2'h1,
    zero_page_mode      = 2'h2,
    pc_offset_mode      = 2'h3
  } mode_type;

  typedef enum logic [3:0] {
    kind_load                    = 4'h0,
    kind_store                   = 4'h1,
    kind_move                    = 4'h2,
    kind_branch                  = 4'h3,
    branch_if_bit_clear          = 4'h4,
    branch_if_bit_set            = 4'h5,
    compare_branch_if_equal      = 4'h6,
    decrement_branch_if_not_zero = 4'h7,
    return_from_interrupt        = 4'h8
  } kind_type;

  typedef enum logic [2:0] {
    st_idle   = 3'h0,
    st_src    = 3'h1,
    st_branch = 3'h3,
    st_done   = 3'h2,
    st_dst    = 3'h6,
    st_write  = 3'h7,
    st_pop    = 3'h5,
    st_fill   = 3'h4
  } state_type;

endpackage

// [branch_test.sv]
`timescale 1ns/10ps
module branch_test (
  // Request
  input  wire operand_addr_pkg::kind_type kind,
  input  wire logic [7:0]                 operand,
  input  wire logic [2:0]                 bit_select,
  input  wire logic [7:0]                 compare,
  input  wire logic                       cond_in,
  // Result
  output logic                            taken,
  output logic [7:0]                      decremented
);

  assign decremented = operand - operand_addr_pkg::DEC_STEP;

  always_comb begin
    unique case (kind)
      operand_addr_pkg::branch_if_bit_clear:          taken = ~operand[bit_select];
      operand_addr_pkg::branch_if_bit_set:            taken = operand[bit_select];
      operand_addr_pkg::compare_branch_if_equal:      taken = (operand == compare);
      operand_addr_pkg::decrement_branch_if_not_zero: taken = (decremented != 8'h00);
      operand_addr_pkg::kind_branch:                  taken = cond_in;
      default:                                        taken = 1'b0;
    endcase
  end

endmodule // branch_test

// [branch_target.sv]
`timescale 1ns/10ps
module branch_target (
  // Inputs
  input  wire logic [15:0] base_pc,
  input  wire logic [7:0]  displacement,
  // Result
  output logic [15:0]      target
);

  // Signed offset widened to the full address before the add
  assign target = base_pc + {{8{displacement[7]}}, displacement};

endmodule // branch_target

// [operand_addr_gen_properties.sv]
`timescale 1ns/10ps
module operand_addr_gen_props (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       reset,
  // Request
  input wire logic                       start,
  input wire operand_addr_pkg::kind_type kind,
  input wire operand_addr_pkg::mode_type src_mode,
  input wire logic                       wide_operand,
  input wire logic [15:0]                opcode_addr,
  // Memory and result
  input wire logic [15:0]                mem_addr,
  input wire logic                       mem_read,
  input wire logic                       mem_write,
  input wire logic                       busy,
  input wire logic                       done,
  input wire logic                       pop_valid,
  input wire logic                       fill_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic       take;
  logic       ret_q;
  logic [2:0] pop_cnt_q;
  logic [2:0] fill_cnt_q;

  assign take = start && !busy;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) ret_q <= 1'b0;
    else if (take) ret_q <= (kind == operand_addr_pkg::return_from_interrupt);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) pop_cnt_q <= 3'h0;
    else if (take) pop_cnt_q <= 3'h0;
    else if (pop_valid) pop_cnt_q <= pop_cnt_q + 3'h1;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) fill_cnt_q <= 3'h0;
    else if (take) fill_cnt_q <= 3'h0;
    else if (fill_valid) fill_cnt_q <= fill_cnt_q + 3'h1;
  end

  AST_READ_PAIR: assert property (mem_read |=> !mem_read)
    else $error("read strobe held past one cycle");
  AST_WRITE_PULSE: assert property (mem_write |-> !mem_read ##1 !mem_write)
    else $error("write strobe overlaps a read or lasts too long");
  AST_REG_ONLY_NO_READ: assert property (take && kind == operand_addr_pkg::kind_load
    && src_mode == operand_addr_pkg::register_only_mode |=> !mem_read [*2])
    else $error("register-only load touched memory");
  AST_INLINE_FIRST_BYTE: assert property (take && kind == operand_addr_pkg::kind_load
    && src_mode == operand_addr_pkg::inline_operand_mode
    |=> ##1 (mem_read && mem_addr == $past(opcode_addr, 2) + 16'h0001))
    else $error("inline operand not read right after opcode");
  AST_WIDE_LOW_NEXT: assert property (take && kind == operand_addr_pkg::kind_load && wide_operand
    && src_mode == operand_addr_pkg::inline_operand_mode
    |=> ##1 mem_read ##2 (mem_read && mem_addr == $past(mem_addr, 2) + 16'h0001))
    else $error("wide operand low byte not at next address");
  AST_ZERO_PAGE_HIGH: assert property (take && kind == operand_addr_pkg::kind_load
    && src_mode == operand_addr_pkg::zero_page_mode
    |=> ##1 mem_read ##2 (mem_read && mem_addr[15:8] == 8'h00))
    else $error("zero-page address high byte not zero");
  AST_BRANCH_DISP_READ: assert property (take && kind == operand_addr_pkg::kind_branch
    && src_mode == operand_addr_pkg::register_only_mode
    |=> ##1 (mem_read && mem_addr == $past(opcode_addr, 2) + 16'h0001))
    else $error("displacement not read right after opcode");
  AST_POP_COUNT: assert property (done && ret_q |-> pop_cnt_q == 3'h5)
    else $error("return popped a wrong number of bytes");
  AST_FILL_COUNT: assert property (done && ret_q |-> fill_cnt_q + 3'(fill_valid) == 3'h3)
    else $error("return refilled a wrong number of bytes");
  AST_FILL_AFTER_POPS: assert property (fill_valid |-> ret_q && pop_cnt_q == 3'h5)
    else $error("refill began before all pops");
endmodule // operand_addr_gen_props

// [mem_space_model.sv]
`timescale 1ns/10ps
module mem_space_model (
  // Clock
  input wire logic        core_clk,
  // Access
  input wire logic [15:0] mem_addr,
  input wire logic        mem_read,
  input wire logic        mem_write,
  input wire logic [7:0]  mem_wdata,
  output logic [7:0]      mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;

  initial for (int k = 0; k < 65536; k++) mem[k] = 8'(k * 7);

  // Idle bus shows the inverse of the last byte, never a stale copy
  assign mem_rdata = mem_read ? mem[mem_addr] : ~last_q;

  always @(posedge core_clk) begin
    if (mem_read) last_q <= mem[mem_addr];
    if (mem_write) mem[mem_addr] <= mem_wdata;
  end
endmodule // mem_space_model

// [cpu_operand_address_generation_tb_top.sv]
`timescale 1ns/10ps
module cpu_operand_address_generation_tb_top;
  logic                       core_clk = 1'b0;
  logic                       reset, start, wide_operand, branch_cond;
  operand_addr_pkg::kind_type kind;
  operand_addr_pkg::mode_type src_mode, dst_mode;
  logic [15:0]                opcode_addr, stack_ptr, mem_addr, operand, operand_addr;
  logic [15:0]                next_pc, stack_out, opc, sp;
  logic [2:0]                 bit_select;
  logic [7:0]                 reg_operand, store_operand, mem_rdata, mem_wdata, pop_data;
  logic [7:0]                 fill_data, v, zp, dsp;
  logic                       mem_read, mem_write, busy, done, branch_taken, pop_valid;
  logic                       fill_valid, t;
  int                         bad_count = 0;
  int                         compares = 0;
  int                         i, j;
  logic [31:0]                seed = 32'hd658;
  logic [7:0]                 popq[$], fillq[$];

  always #20 core_clk = ~core_clk;

  operand_addr_gen dut (.core_clk, .reset, .start, .kind, .src_mode, .dst_mode,
    .wide_operand, .opcode_addr, .bit_select, .reg_operand, .store_operand, .stack_ptr,
    .branch_cond, .mem_addr, .mem_read, .mem_write, .mem_wdata, .mem_rdata, .busy, .done,
    .operand, .operand_addr, .next_pc, .branch_taken, .stack_out, .pop_valid, .pop_data,
    .fill_valid, .fill_data);
  mem_space_model pm (.core_clk, .mem_addr, .mem_read, .mem_write, .mem_wdata, .mem_rdata);

  always @(posedge core_clk) begin
    if (pop_valid === 1'b1) popq.push_back(pop_data);
    if (fill_valid === 1'b1) fillq.push_back(fill_data);
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [15:0] target(input logic [15:0] after, input logic [7:0] d,
                                         input logic tk);
    return tk ? after + {{8{d[7]}}, d} : after;
  endfunction

  function automatic logic tested(input operand_addr_pkg::kind_type k, input logic [7:0] b);
    case (k)
      operand_addr_pkg::branch_if_bit_clear: return !b[bit_select];
      operand_addr_pkg::branch_if_bit_set: return b[bit_select];
      operand_addr_pkg::compare_branch_if_equal: return b == reg_operand;
      default: return (b - 8'h01) != 8'h00;
    endcase
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Start stays up one extra cycle while busy, which must be ignored
  task automatic req(input operand_addr_pkg::kind_type k, input operand_addr_pkg::mode_type s);
    int n;
    kind = k;
    src_mode = s;
    opcode_addr = opc;
    start = 1'b1;
    @(posedge core_clk) #2;
    @(posedge core_clk) #2;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge core_clk) #2;
      n++;
    end
    if (n == 40) check("done", 16'h0, 16'h1);
  endtask

  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #400000;
    bad_count++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    {start, wide_operand, branch_cond, bit_select} = 6'h00;
    kind = operand_addr_pkg::kind_load;
    src_mode = operand_addr_pkg::register_only_mode;
    dst_mode = operand_addr_pkg::register_only_mode;
    {opcode_addr, stack_ptr, reg_operand, store_operand} = 48'h0;
    opc = 16'h2000;
    repeat (5) @(posedge core_clk);
    #2 reset = 1'b0;
    for (i = 0; i < 6; i++) begin
      opc = {4'h2, rnd(), 4'h0};
      bit_select = 3'(i);
      reg_operand = rnd();
      store_operand = rnd();
      req(operand_addr_pkg::kind_load,
          i[0] ? operand_addr_pkg::pc_offset_mode : operand_addr_pkg::register_only_mode);
      check("reg operand", operand, {8'h00, reg_operand});
      v = rnd();
      zp = rnd();
      pm.mem[opc + 16'h1] = zp;
      pm.mem[opc + 16'h2] = v;
      wide_operand = 1'b1;
      req(operand_addr_pkg::kind_load, operand_addr_pkg::inline_operand_mode);
      check("wide operand", operand, {zp, v});
      check("wide next", next_pc, opc + 16'h3);
      wide_operand = 1'b0;
      req(operand_addr_pkg::kind_load, operand_addr_pkg::inline_operand_mode);
      check("inline operand", operand, {8'h00, zp});
      pm.mem[{8'h00, zp}] = v;
      req(operand_addr_pkg::kind_load, operand_addr_pkg::zero_page_mode);
      check("zp operand", operand, {8'h00, v});
      check("zp address", operand_addr, {8'h00, zp});
      dst_mode = operand_addr_pkg::zero_page_mode;
      req(operand_addr_pkg::kind_move, operand_addr_pkg::inline_operand_mode);
      dst_mode = operand_addr_pkg::register_only_mode;
      check("moved byte", {8'h00, pm.mem[{8'h00, v}]}, {8'h00, zp});
      dst_mode = operand_addr_pkg::zero_page_mode;
      req(operand_addr_pkg::kind_store, operand_addr_pkg::register_only_mode);
      dst_mode = operand_addr_pkg::register_only_mode;
      check("stored byte", {8'h00, pm.mem[{8'h00, zp}]}, {8'h00, store_operand});
      check("store address", operand_addr, {8'h00, zp});
      check("store next", next_pc, opc + 16'h2);
      dsp = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : rnd();
      branch_cond = i[0];
      pm.mem[opc + 16'h1] = dsp;
      req(operand_addr_pkg::kind_branch, operand_addr_pkg::register_only_mode);
      check("branch taken", {15'h0, branch_taken}, {15'h0, branch_cond});
      check("branch next", next_pc, target(opc + 16'h2, dsp, branch_cond));
      for (j = 4; j < 8; j++) begin
        v = (i == 0) ? 8'h01 : rnd();
        if (i[0]) reg_operand = v;
        pm.mem[opc + 16'h1] = zp;
        pm.mem[{8'h00, zp}] = v;
        pm.mem[opc + 16'h2] = dsp;
        t = tested(operand_addr_pkg::kind_type'(4'(j)), v);
        req(operand_addr_pkg::kind_type'(4'(j)), operand_addr_pkg::zero_page_mode);
        check("test taken", {15'h0, branch_taken}, {15'h0, t});
        check("test next", next_pc, target(opc + 16'h3, dsp, t));
        if (j == 7) check("decremented", {8'h00, pm.mem[{8'h00, zp}]}, {8'h00, v - 8'h01});
      end
      sp = {8'h01, rnd()};
      for (j = 1; j < 4; j++) pm.mem[sp + 16'(j)] = rnd();
      pm.mem[sp + 16'h4] = opc[15:8];
      pm.mem[sp + 16'h5] = opc[7:0];
      popq.delete();
      fillq.delete();
      stack_ptr = sp;
      // Handler has already cleared its source flag
      req(operand_addr_pkg::return_from_interrupt,
          operand_addr_pkg::register_only_mode);
      @(posedge core_clk) #2;
      for (j = 0; j < 5; j++) check("popped", {8'h00, popq[j]}, {8'h00, pm.mem[sp + 16'(j + 1)]});
      for (j = 0; j < 3; j++) check("refill", {8'h00, fillq[j]}, {8'h00, pm.mem[opc + 16'(j)]});
      check("restored pc", next_pc, opc);
      check("stack after", stack_out, sp + 16'h5);
    end
    close_out();
  end
endmodule // cpu_operand_address_generation_tb_top

bind operand_addr_gen operand_addr_gen_props props (.core_clk, .reset, .start, .kind,
  .src_mode, .wide_operand, .opcode_addr, .mem_addr, .mem_read, .mem_write, .busy, .done,
  .pop_valid, .fill_valid);
